// ==== rtl/uhb_cfg.svh ====
`ifndef UHB_CFG_SVH
`define UHB_CFG_SVH

// Command codes: bit 7 set means write, the low seven bits select the register.
`define UHB_CMD_WR_BIT      7
`define UHB_IDX_XFER_CNT    7'h22
`define UHB_IDX_IRQ_STAT    7'h24
`define UHB_IDX_IRQ_MASK    7'h25
`define UHB_IDX_ISO_LEN     7'h2a
`define UHB_IDX_ACK_LEN     7'h2b
`define UHB_IDX_FILL_STAT   7'h2c
`define UHB_IDX_DMA_CFG     7'h30
`define UHB_IDX_ISO_PORT    7'h40
`define UHB_IDX_ACK_PORT    7'h41

// Reset values.
`define UHB_ACK_LEN_RST     16'h1000
`define UHB_ISO_LEN_RST     16'h0000
`define UHB_XFER_CNT_RST    16'h0000

// Fill status fields.
`define UHB_FULL_LSB        0
`define UHB_EMPTY_LSB       8
`define UHB_HALF_BIT        12
`define UHB_TGT_ISO0        2'd0
`define UHB_TGT_ISO1        2'd1
`define UHB_TGT_ACK         2'd2

// Interrupt status fields.
`define UHB_IRQ_ISO_BIT     0
`define UHB_IRQ_ACK_BIT     1
`define UHB_IRQ_EOT_BIT     2

// DMA configuration fields.
`define UHB_DMA_EN_BIT      0
`define UHB_DMA_DIR_BIT     1
`define UHB_DMA_BURST_LSB   2
`define UHB_DMA_REGION_BIT  4
`define UHB_BURST_N0        4'd1
`define UHB_BURST_N1        4'd1
`define UHB_BURST_N2        4'd4
`define UHB_BURST_N3        4'd8

// Descriptor header word carrying format and target function address.
`define UHB_DESC_WORD       2'd3
`define UHB_DESC_FMT_BIT    7
`define UHB_DESC_ADDR_MSB   6

// Host Wishbone map, byte addresses.
`define UHB_WB_CMD          8'h00
`define UHB_WB_STAT         8'h04
`define UHB_WB_DMA          8'h08
`define UHB_WB_DESC         8'h0c

`endif

// ==== rtl/uhb_pkg.sv ====
package uhb_pkg;
  typedef logic [7:0]  uhb_code_t;
  typedef logic [15:0] uhb_word_t;
  typedef enum logic {
    st_idle,
    st_wait
  } uhb_host_st_e;
endpackage

// ==== rtl/uhb_link.sv ====
interface uhb_link;
  logic               req;
  uhb_pkg::uhb_code_t code;
  uhb_pkg::uhb_word_t wdata;
  uhb_pkg::uhb_word_t rdata;
  logic               ack;
  logic               dreq;
  logic               dack;

  modport dev (input req, input code, input wdata, input dack, output rdata, output ack, output dreq);
  modport host (output req, output code, output wdata, output dack, input rdata, input ack, input dreq);
endinterface

// ==== rtl/uhb_device.sv ====
// Notes on behaviour
// - Format bit: 0 acknowledged, 1 isochronous.
// - Descriptor carries seven-bit target function address.
// - One shared four kilobyte buffer memory.
// - Memory split into ack and iso regions.
// - Ack region is one non-alternating buffer.
// - Both iso halves share one programmed length.
// - Processor and engine use opposite iso halves.
// - Processor may load either iso half.
// - Ack length read 2BH, written ABH.
// - Iso length read 2AH, written AAH.
// - Lengths accepted at any time.
// - Software keeps ack plus twice iso within 1000H.
// - Each iso half holds up to two kilobytes.
// - Read-only fill status at 2CH shows empty/full.
// - Each buffer interrupt source individually maskable.
// - Data moves by programmed I/O or DMA.
// - DMA single cycle or bursts of 1, 4, 8.
`include "uhb_cfg.svh"

module uhb_device #(
  parameter int MEM_BYTES = 4096,
  parameter int HALF_MAX  = 2048
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  uhb_link.dev                   link,
  input  wire logic              sof_i,
  input  wire logic              eng_iso_i,
  input  wire logic [11:0]       eng_addr_i,
  input  wire logic              eng_we_i,
  input  wire logic [15:0]       eng_wdata_i,
  input  wire logic [1:0]        eng_desc_word_i,
  input  wire logic [2:0]        eng_set_full_i,
  input  wire logic [2:0]        eng_clr_full_i,
  output      logic [15:0]       eng_rdata_o,
  output      logic              desc_iso_o,
  output      logic [6:0]        desc_func_addr_o,
  output      logic              iso_cpu_half_o,
  output      logic              irq_o
);
  localparam int WORDS = MEM_BYTES / 2;

  generate
    if (MEM_BYTES != 4096 || HALF_MAX > MEM_BYTES / 2) begin : g_bad
      $error("uhb_device: memory must be 4096 bytes with halves of at most half of it");
    end
  endgenerate

  logic [15:0] mem [WORDS];
  logic [15:0] xfer_cnt;
  logic [15:0] iso_len;
  logic [15:0] ack_len;
  logic [2:0]  full;
  logic [2:0]  irq_st;
  logic [2:0]  irq_mask;
  logic [4:0]  dma_cfg;
  logic        cpu_half;
  logic [12:0] ptr;
  logic [3:0]  burst_cnt;
  logic        ack_q;
  logic [15:0] rdata_q;
  logic        dreq_q;

  logic        acc;
  logic        wr;
  logic [6:0]  idx;
  logic        mv;
  logic        mv_iso;
  logic        mv_wr;
  logic [12:0] ptr_nx;
  logic        eot;
  logic [1:0]  tgt;
  logic [11:0] cpu_byte;
  logic [11:0] eng_byte;
  logic [2:0]  set_full;
  logic [2:0]  clr_full;
  logic [3:0]  burst_len;
  logic [15:0] fill_stat;
  logic [15:0] reg_rd;

  assign acc    = link.req & ~ack_q;
  assign wr     = link.code[`UHB_CMD_WR_BIT];
  assign idx    = link.code[6:0];
  assign mv     = (acc && (idx == `UHB_IDX_ISO_PORT || idx == `UHB_IDX_ACK_PORT)) || link.dack;
  assign mv_iso = (mv && !link.dack) ? (idx == `UHB_IDX_ISO_PORT) : dma_cfg[`UHB_DMA_REGION_BIT];
  assign mv_wr  = link.dack ? dma_cfg[`UHB_DMA_DIR_BIT] : wr;
  assign ptr_nx = ptr + 13'd2;
  assign eot    = mv && (ptr_nx >= {1'b0, xfer_cnt[11:0]} || ptr_nx[12]);
  assign tgt    = !mv_iso ? `UHB_TGT_ACK : (cpu_half ? `UHB_TGT_ISO1 : `UHB_TGT_ISO0);

  // Halves sit straight after the ack region, the second right after the first.
  always_comb begin
    cpu_byte = ptr[11:0];
    if (mv_iso) begin
      cpu_byte = ack_len[11:0] + ptr[11:0] + (cpu_half ? iso_len[11:0] : 12'h000);
    end
  end

  // The engine always works on the half the processor is not using.
  always_comb begin
    eng_byte = eng_addr_i;
    if (eng_iso_i) begin
      eng_byte = ack_len[11:0] + eng_addr_i + (cpu_half ? 12'h000 : iso_len[11:0]);
    end
  end

  always_comb begin
    set_full = eng_set_full_i;
    clr_full = eng_clr_full_i;
    if (eot && mv_wr) begin
      set_full[tgt] = 1'b1;
    end
    if (eot && !mv_wr) begin
      clr_full[tgt] = 1'b1;
    end
  end

  always_comb begin
    unique case (dma_cfg[`UHB_DMA_BURST_LSB +: 2])
      2'd0: burst_len = `UHB_BURST_N0;
      2'd1: burst_len = `UHB_BURST_N1;
      2'd2: burst_len = `UHB_BURST_N2;
      2'd3: burst_len = `UHB_BURST_N3;
    endcase
  end

  always_comb begin
    fill_stat = 16'h0000;
    fill_stat[`UHB_FULL_LSB +: 3]  = full;
    fill_stat[`UHB_EMPTY_LSB +: 3] = ~full;
    fill_stat[`UHB_HALF_BIT]       = cpu_half;
  end

  always_comb begin
    unique case (idx)
      `UHB_IDX_XFER_CNT:  reg_rd = xfer_cnt;
      `UHB_IDX_IRQ_STAT:  reg_rd = {13'h0000, irq_st};
      `UHB_IDX_IRQ_MASK:  reg_rd = {13'h0000, irq_mask};
      `UHB_IDX_ISO_LEN:   reg_rd = iso_len;
      `UHB_IDX_ACK_LEN:   reg_rd = ack_len;
      `UHB_IDX_FILL_STAT: reg_rd = fill_stat;
      `UHB_IDX_DMA_CFG:   reg_rd = {11'h000, dma_cfg};
      default:            reg_rd = 16'h0000;
    endcase
  end

  // Lengths may change at any moment; contents already placed are not moved.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_len  <= `UHB_ACK_LEN_RST;
      iso_len  <= `UHB_ISO_LEN_RST;
      xfer_cnt <= `UHB_XFER_CNT_RST;
      irq_mask <= 3'h0;
      dma_cfg  <= 5'h00;
    end else if (acc && wr) begin
      unique case (idx)
        `UHB_IDX_ACK_LEN:  ack_len  <= link.wdata;
        `UHB_IDX_ISO_LEN:  iso_len  <= link.wdata;
        `UHB_IDX_XFER_CNT: xfer_cnt <= link.wdata;
        `UHB_IDX_IRQ_MASK: irq_mask <= link.wdata[2:0];
        `UHB_IDX_DMA_CFG:  dma_cfg  <= link.wdata[4:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ptr <= 13'h0000;
    end else if (eot || (acc && wr && idx == `UHB_IDX_XFER_CNT)) begin
      ptr <= 13'h0000;
    end else if (mv) begin
      ptr <= ptr_nx;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q   <= 1'b0;
      rdata_q <= 16'h0000;
    end else begin
      ack_q <= acc;
      if (acc && !mv) begin
        rdata_q <= reg_rd;
      end else if (mv && !mv_wr) begin
        rdata_q <= mem[cpu_byte[11:1]];
      end
    end
  end

  // A processor write wins over an engine write to the same word.
  always_ff @(posedge clk_i) begin
    if (eng_we_i) begin
      mem[eng_byte[11:1]] <= eng_wdata_i;
    end
    if (mv && mv_wr) begin
      mem[cpu_byte[11:1]] <= link.wdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      eng_rdata_o      <= 16'h0000;
      desc_iso_o       <= 1'b0;
      desc_func_addr_o <= 7'h00;
    end else begin
      eng_rdata_o <= mem[eng_byte[11:1]];
      if (eng_desc_word_i == `UHB_DESC_WORD && !eng_we_i) begin
        desc_iso_o       <= mem[eng_byte[11:1]][`UHB_DESC_FMT_BIT];
        desc_func_addr_o <= mem[eng_byte[11:1]][`UHB_DESC_ADDR_MSB:0];
      end
    end
  end

  // Set wins over clear so an event in the clearing cycle is kept.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      full <= 3'h0;
    end else begin
      full <= (full & ~clr_full) | set_full;
    end
  end

  // Ping-pong swaps on each frame start, but goes to half 1 when both halves are full.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cpu_half <= 1'b0;
    end else if (sof_i) begin
      cpu_half <= (full[0] && full[1]) ? 1'b1 : ~cpu_half;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_st <= 3'h0;
    end else begin
      irq_st <= (irq_st & ~((acc && wr && idx == `UHB_IDX_IRQ_STAT) ? link.wdata[2:0] : 3'h0))
              | {eot, |eng_set_full_i[2] , |eng_set_full_i[1:0]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_st & irq_mask);
    end
  end

  // The request drops for one cycle after each burst so the host sees its end.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dreq_q    <= 1'b0;
      burst_cnt <= 4'h0;
    end else if (!dma_cfg[`UHB_DMA_EN_BIT]) begin
      dreq_q    <= 1'b0;
      burst_cnt <= 4'h0;
    end else if (dreq_q && link.dack) begin
      if (burst_cnt + 4'h1 == burst_len || eot) begin
        dreq_q    <= 1'b0;
        burst_cnt <= 4'h0;
      end else begin
        burst_cnt <= burst_cnt + 4'h1;
      end
    end else if (!dreq_q && !acc) begin
      dreq_q <= dma_cfg[`UHB_DMA_DIR_BIT] ? ~full[tgt] : full[tgt];
    end
  end

  assign link.ack       = ack_q;
  assign link.rdata     = rdata_q;
  assign link.dreq      = dreq_q;
  assign iso_cpu_half_o = cpu_half;
endmodule

// ==== rtl/uhb_host.sv ====
`include "uhb_cfg.svh"

module uhb_host (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  uhb_link.host            link,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output      logic [31:0] wb_dat_o,
  output      logic        wb_ack_o
);
  uhb_pkg::uhb_host_st_e st;
  uhb_pkg::uhb_code_t    code_q;
  uhb_pkg::uhb_word_t    wdata_q;
  uhb_pkg::uhb_word_t    last_rd;
  uhb_pkg::uhb_word_t    dma_word;
  uhb_pkg::uhb_word_t    dma_rd;
  logic                  dma_arm;
  logic                  dack_q;
  logic                  wb_req;
  logic                  wb_wr;

  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr  = wb_req & wb_we_i & (wb_sel_i == 4'hf);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      unique case (wb_adr_i)
        `UHB_WB_STAT: wb_dat_o <= {last_rd, 15'h0000, st == uhb_pkg::st_wait};
        `UHB_WB_DMA:  wb_dat_o <= {15'h0000, dma_arm, dma_rd};
        default:      wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // Command register, or descriptor word built from format and address fields.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st      <= uhb_pkg::st_idle;
      code_q  <= 8'h00;
      wdata_q <= 16'h0000;
      last_rd <= 16'h0000;
    end else begin
      unique case (st)
        uhb_pkg::st_idle: begin
          if (wb_wr && wb_adr_i == `UHB_WB_CMD) begin
            code_q  <= wb_dat_i[23:16];
            wdata_q <= wb_dat_i[15:0];
            st      <= uhb_pkg::st_wait;
          end else if (wb_wr && wb_adr_i == `UHB_WB_DESC) begin
            code_q  <= wb_dat_i[15:8];
            wdata_q <= {8'h00, wb_dat_i[`UHB_DESC_FMT_BIT], wb_dat_i[`UHB_DESC_ADDR_MSB:0]};
            st      <= uhb_pkg::st_wait;
          end
        end
        uhb_pkg::st_wait: begin
          if (link.ack) begin
            last_rd <= link.rdata;
            st      <= uhb_pkg::st_idle;
          end
        end
      endcase
    end
  end

  // One DMA word is armed at a time; write data and read capture share it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dma_arm  <= 1'b0;
      dma_word <= 16'h0000;
      dack_q   <= 1'b0;
      dma_rd   <= 16'h0000;
    end else begin
      dack_q <= link.dack;
      if (dack_q) begin
        dma_rd <= link.rdata;
      end
      if (link.dack) begin
        dma_arm <= 1'b0;
      end else if (wb_wr && wb_adr_i == `UHB_WB_DMA) begin
        dma_arm  <= 1'b1;
        dma_word <= wb_dat_i[15:0];
      end
    end
  end

  // No DMA beat is given while a command is open, so pointer updates never clash.
  assign link.dack  = link.dreq & dma_arm & ~dack_q & (st == uhb_pkg::st_idle);
  assign link.req   = (st == uhb_pkg::st_wait);
  assign link.code  = code_q;
  assign link.wdata = link.dack ? dma_word : wdata_q;
endmodule

// ==== tb/uhb_link_properties.sv ====
module uhb_link_properties (
  input wire logic               clk_i,
  input wire logic               rst_i,
  input wire logic               req,
  input wire uhb_pkg::uhb_code_t code,
  input wire uhb_pkg::uhb_word_t wdata,
  input wire logic               ack,
  input wire logic               dreq,
  input wire logic               dack
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_open;
    req && !ack;
  endsequence
  sequence s_answer;
    ack ##1 !ack;
  endsequence
  property p_answer;
    s_open |=> s_answer;
  endproperty
  a_answer: assert property (p_answer) else $error("Late link answer.");
  property p_hold;
    s_open |=> $stable(code) && $stable(wdata);
  endproperty
  a_hold: assert property (p_hold) else $error("Command moved while open.");
  property p_release;
    ack |=> !req;
  endproperty
  a_release: assert property (p_release) else $error("Request kept after answer.");
  property p_ack_cause;
    $rose(ack) |-> $past(req);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("Answer without request.");
  property p_no_spurious;
    !req |=> !ack;
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("Spurious answer.");
  property p_dack_single;
    dack |=> !dack;
  endproperty
  a_dack_single: assert property (p_dack_single) else $error("Back to back DMA word.");
  // A DMA word and a command share the data lines, so they must never overlap.
  property p_dack_quiet;
    dack |-> !req;
  endproperty
  a_dack_quiet: assert property (p_dack_quiet) else $error("DMA word during command.");
  property p_dack_dreq;
    dack |-> dreq;
  endproperty
  a_dack_dreq: assert property (p_dack_dreq) else $error("DMA word without request.");
endmodule

// ==== tb/usb_host_buffer_ram_partition_test.sv ====
module usb_host_buffer_ram_partition_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i, rst_i, sof_i, eng_iso_i, wb_cyc_i, wb_stb_i, wb_we_i, desc_iso_o, iso_cpu_half_o, irq_o;
  logic        wb_ack_o;
  logic [11:0] eng_addr_i;
  logic [15:0] eng_rdata_o;
  logic [1:0]  eng_desc_word_i;
  logic [2:0]  eng_set_full_i, eng_clr_full_i;
  logic [7:0]  wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [6:0]  desc_func_addr_o;
  int          errors, comparisons, cycles, run_cnt, first_run;
  uhb_link     link ();
  uhb_device u_uhb_device (.clk_i(clk_i), .rst_i(rst_i), .link(link.dev), .sof_i(sof_i), .eng_iso_i(eng_iso_i),
    .eng_addr_i(eng_addr_i), .eng_we_i(1'b0), .eng_wdata_i(16'h0000), .eng_desc_word_i(eng_desc_word_i),
    .eng_set_full_i(eng_set_full_i), .eng_clr_full_i(eng_clr_full_i), .eng_rdata_o(eng_rdata_o),
    .desc_iso_o(desc_iso_o), .desc_func_addr_o(desc_func_addr_o), .iso_cpu_half_o(iso_cpu_half_o), .irq_o(irq_o));
  uhb_host u_uhb_host (.clk_i(clk_i), .rst_i(rst_i), .link(link.host), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o));
  uhb_link_properties u_uhb_link_properties (.clk_i(clk_i), .rst_i(rst_i), .req(link.req), .code(link.code),
    .wdata(link.wdata), .ack(link.ack), .dreq(link.dreq), .dack(link.dack));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  task automatic stop_test();
    $display("Counts: %0d comparisons, %0d errors", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      stop_test();
    end
  end
  // Length of the first DMA request run, used to judge the burst size.
  always @(posedge clk_i) begin
    if (link.dack === 1'b1) begin
      run_cnt <= run_cnt + 1;
    end else if (link.dreq !== 1'b1 && run_cnt != 0) begin
      if (first_run == 0) begin
        first_run <= run_cnt;
      end
      run_cnt <= 0;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // Polling the busy flag keeps the bench free of any assumed link latency.
  task automatic wait_idle();
    do wb(1'b0, 8'h04, 32'h0); while (rd[0] !== 1'b0);
  endtask
  task automatic cmd(input logic [6:0] idx, input logic [15:0] d, input logic we);
    wb(1'b1, 8'h00, {8'h00, we, idx, d});
    wait_idle();
  endtask
  task automatic eng_rd(input logic iso, input logic [11:0] a, input logic [15:0] exp);
    eng_iso_i <= iso;
    eng_addr_i <= a;
    repeat (3) @(posedge clk_i);
    check(eng_rdata_o, exp);
  endtask
  task automatic pulse_sof();
    sof_i <= 1'b1;
    @(posedge clk_i);
    sof_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic test_regs();
    cmd(7'h2b, 16'h0, 1'b0);
    check(rd[31:16], 32'h1000);
    cmd(7'h2a, 16'h0, 1'b0);
    check(rd[31:16], 32'h0);
    cmd(7'h2c, 16'h0, 1'b0);
    check({rd[28], rd[26:24], rd[18:16]}, 32'h38);
    cmd(7'h2a, 16'h0800, 1'b1);
    cmd(7'h2b, 16'h0000, 1'b1);
    cmd(7'h2a, 16'h0, 1'b0);
    check(rd[31:16], 32'h0800);
    cmd(7'h2b, 16'h0010, 1'b1);
    cmd(7'h2a, 16'h0008, 1'b1);
    cmd(7'h2b, 16'h0, 1'b0);
    check(rd[31:16], 32'h0010);
    cmd(7'h2c, 16'hffff, 1'b1);
    cmd(7'h2c, 16'h0, 1'b0);
    check(rd[18:16], 32'h0);
    cmd(7'h7f, 16'h0, 1'b0);
    check(rd[31:16], 32'h0);
    wb(1'b0, 8'h10, 32'h0);
    check(rd, 32'h0);
    $display("test_regs done");
  endtask
  task automatic test_pio();
    cmd(7'h22, 16'h0004, 1'b1);
    cmd(7'h41, 16'h1234, 1'b1);
    cmd(7'h41, 16'h5678, 1'b1);
    cmd(7'h2c, 16'h0, 1'b0);
    check(rd[18], 32'h1);
    eng_rd(1'b0, 12'h000, 16'h1234);
    eng_rd(1'b0, 12'h002, 16'h5678);
    check(irq_o, 32'h0);
    cmd(7'h25, 16'h0004, 1'b1);
    check(irq_o, 32'h1);
    cmd(7'h24, 16'h0004, 1'b1);
    check(irq_o, 32'h0);
    cmd(7'h22, 16'h0002, 1'b1);
    cmd(7'h40, 16'hbeef, 1'b1);
    pulse_sof();
    check(iso_cpu_half_o, 32'h1);
    eng_rd(1'b1, 12'h000, 16'hbeef);
    eng_rd(1'b0, 12'h000, 16'h1234);
    eng_set_full_i <= 3'b011;
    @(posedge clk_i);
    eng_set_full_i <= 3'b000;
    pulse_sof();
    check(iso_cpu_half_o, 32'h1);
    $display("test_pio done");
  endtask
  task automatic test_desc();
    for (int f = 0; f < 2; f++) begin
      cmd(7'h22, 16'h0008, 1'b1);
      repeat (3) cmd(7'h41, 16'h0000, 1'b1);
      wb(1'b1, 8'h0c, {16'h0000, 8'hc1, f[0], 7'h05 ^ {7{f[0]}}});
      wait_idle();
      eng_desc_word_i <= 2'd3;
      eng_rd(1'b0, 12'h006, {8'h00, f[0], 7'h05 ^ {7{f[0]}}});
      check(desc_iso_o, f[0]);
      check(desc_func_addr_o, 7'h05 ^ {7{f[0]}});
    end
    $display("test_desc done");
  endtask
  task automatic test_dma();
    int bl[4];
    bl = '{1, 1, 4, 8};
    for (int b = 0; b < 4; b++) begin
      cmd(7'h22, 16'h0010, 1'b1);
      eng_clr_full_i <= 3'b100;
      @(posedge clk_i);
      eng_clr_full_i <= 3'b000;
      first_run = 0;
      cmd(7'h30, {11'h0, 1'b0, b[1:0], 2'b11}, 1'b1);
      for (int w = 0; w < 8; w++) begin
        wb(1'b1, 8'h08, {16'h0, 8'h00, b[3:0], w[3:0]});
        do wb(1'b0, 8'h08, 32'h0); while (rd[16] !== 1'b0);
      end
      check(first_run, bl[b]);
      cmd(7'h30, 16'h0, 1'b1);
    end
    eng_rd(1'b0, 12'h00e, 16'h0037);
    cmd(7'h22, 16'h0002, 1'b1);
    eng_clr_full_i <= 3'b010;
    @(posedge clk_i);
    eng_clr_full_i <= 3'b000;
    cmd(7'h30, 16'h0013, 1'b1);
    wb(1'b1, 8'h08, 32'h0000_a55a);
    do wb(1'b0, 8'h08, 32'h0); while (rd[16] !== 1'b0);
    cmd(7'h2c, 16'h0, 1'b0);
    check(rd[17], 32'h1);
    eng_rd(1'b0, 12'h018, 16'ha55a);
    cmd(7'h30, 16'h0001, 1'b1);
    wb(1'b1, 8'h08, 32'h0);
    do wb(1'b0, 8'h08, 32'h0); while (rd[16] !== 1'b0);
    check(rd[15:0], 32'h0030);
    cmd(7'h2c, 16'h0, 1'b0);
    check(rd[18], 32'h0);
    $display("test_dma done");
  endtask
  initial begin
    errors = 0;
    comparisons = 0;
    cycles = 0;
    run_cnt = 0;
    first_run = 0;
    rst_i = 1'b1;
    sof_i = 1'b0;
    eng_iso_i = 1'b0;
    eng_addr_i = 12'h000;
    eng_desc_word_i = 2'd0;
    eng_set_full_i = 3'b000;
    eng_clr_full_i = 3'b000;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    test_regs();
    test_pio();
    test_desc();
    test_dma();
    stop_test();
  end
endmodule
